/* File: sddc_defines.vh */
// Purpose: Offsets, field positions, reset values and timing counts for the supply drop detector block
// Assumes: APB with 32-bit data, one aligned word per register, 25 MHz clock
// Notes:   Definitions only
`ifndef SDDC_DEFINES_VH
`define SDDC_DEFINES_VH

// Register byte offsets
`define SDDC_OFF_CONTROL      12'h000
`define SDDC_OFF_IRQ_CONTROL  12'h004
`define SDDC_OFF_STATUS       12'h008
`define SDDC_OFF_MASK         12'h00C
`define SDDC_OFF_SLEEP        12'h010

// Detector control register fields
`define SDDC_BIT_DET_EN       4
`define SDDC_BIT_REF_STABLE   5
`define SDDC_LVL_HI           2
`define SDDC_CONTROL_RESET    8'h04
`define SDDC_LVL_RESET        3'h4
`define SDDC_CONTROL_WMASK    8'h17

// Interrupt control register fields
`define SDDC_BIT_FLAG         0
`define SDDC_BIT_FLAG_IE      1
`define SDDC_BIT_PERIPH_IE    2
`define SDDC_BIT_GLOBAL_IE    3

// Event status and mask bits
`define SDDC_EV_FLAG_SET      0
`define SDDC_EV_WAKE          1
`define SDDC_EV_WIDTH         2

// Reference settling time in ns and its cycle count (rounded up, 40 ns period)
`define SDDC_CLK_PERIOD_NS    40
`define SDDC_SETTLE_NS        20000
`define SDDC_SETTLE_CYCLES    ((`SDDC_SETTLE_NS + `SDDC_CLK_PERIOD_NS - 1) / `SDDC_CLK_PERIOD_NS)
`define SDDC_CNT_WIDTH        10

`endif

/* File: sddc_supply_drop_detect.v */
// Purpose: Control and event logic of a programmable supply drop detector, with an APB register slave
// Assumes: Comparator output arrives asynchronously and is synchronised here; one 25 MHz clock
// Notes:   Analog trip comparison lives outside; this block drives its power and level inputs
//
// Summary of operation
// RULE1 - Enable bit powers detector and reference
// RULE2 - Three-bit trip level, default code 100
// RULE3 - Falling supply edge sets undervoltage flag
// RULE4 - Flag stays set until software clears
// RULE5 - Interrupt needs flag and all enables (core_irq_req only; irq follows sticky status and mask)
// RULE6 - Software write may set the flag
// RULE7 - Flag with enables wakes sleeping core
// RULE8 - Global enable adds vector after wake
// RULE9 - Read-only reference-stable status bit five
// RULE10 - Stable bit valid only with fast oscillator
// RULE11 - Software enables, programs, waits, then clears
// RULE12 - Disabled detector never sets flag, stable zero
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sddc_defines.vh"

module sddc_supply_drop_detect (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Analog front end
    input  wire        supply_below_trip,
    input  wire        fast_osc_running,
    output reg         detector_power,
    output reg  [2:0]  trip_level_select,
    // Core hooks
    input  wire        core_sleeping,
    output reg         core_wake,
    output reg         core_irq_req,
    output reg         irq
);

    // Settling count, cut on purpose to the counter width
    localparam integer               SETTLE_N   = `SDDC_SETTLE_CYCLES;
    localparam [`SDDC_CNT_WIDTH-1:0] SETTLE_CNT = SETTLE_N[`SDDC_CNT_WIDTH-1:0];

    // Stored state
    reg [7:0]                 control_q;     // Detector control register
    reg                       flag_q;        // Undervoltage flag
    reg                       flag_ie_q;     // Individual enable
    reg                       periph_ie_q;   // Peripheral enable
    reg                       global_ie_q;   // Global enable
    reg [`SDDC_EV_WIDTH-1:0]  status_q;      // Sticky events
    reg [`SDDC_EV_WIDTH-1:0]  mask_q;        // Event mask
    reg                       vector_pend_q; // Vector owed after wake
    reg [`SDDC_CNT_WIDTH-1:0] settle_q;      // Reference settle counter
    reg                       settled_q;     // Reference has settled
    reg [2:0]                 below_sync_q;  // Comparator synchroniser
    reg [2:0]                 osc_sync_q;    // Oscillator synchroniser
    reg                       below_q;       // Filtered comparator level
    reg                       osc_q;         // Filtered oscillator level

    // Decoded access strobes
    wire access  = psel & penable;
    wire wr      = access & pwrite;
    wire rd      = access & ~pwrite;
    wire hit_ctl = (paddr == `SDDC_OFF_CONTROL);
    wire hit_irc = (paddr == `SDDC_OFF_IRQ_CONTROL);
    wire hit_sts = (paddr == `SDDC_OFF_STATUS);
    wire hit_msk = (paddr == `SDDC_OFF_MASK);
    wire hit_slp = (paddr == `SDDC_OFF_SLEEP);
    wire mapped  = hit_ctl | hit_irc | hit_sts | hit_msk | hit_slp;
    wire det_en  = control_q[`SDDC_BIT_DET_EN];

    // Stable bit as software sees it: settled, enabled and oscillator running
    wire ref_stable = settled_q & det_en & osc_q; // RULE9 RULE10 RULE12

    // Synchronised comparator: a change counts once stages two and three agree
    wire below_d = (below_sync_q[2] == below_sync_q[1]) ? below_sync_q[1] : below_q;
    wire osc_d   = (osc_sync_q[2] == osc_sync_q[1]) ? osc_sync_q[1] : osc_q;

    // Rising "below trip" means the supply has just fallen through the level
    wire drop_edge = below_d & ~below_q & det_en; // RULE3 RULE12

    // Software write to the flag
    wire flag_wr    = wr & hit_irc;
    wire flag_wdata = pwdata[`SDDC_BIT_FLAG];

    // Flag next value: hardware set wins over a software clear
    wire flag_d = drop_edge | (flag_wr ? flag_wdata : flag_q); // RULE4 RULE6
    wire flag_rise = flag_d & ~flag_q;

    // Wake and interrupt conditions on the next flag value
    wire wake_cond = flag_d & flag_ie_q & periph_ie_q;              // RULE7
    wire irq_cond  = flag_d & flag_ie_q & periph_ie_q & global_ie_q; // RULE5

    // Event sources for the sticky status register
    wire [`SDDC_EV_WIDTH-1:0] events = {wake_cond & core_sleeping, flag_rise};

    // Read data mux
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_ctl) begin
            rdata_d[7:0] = control_q & `SDDC_CONTROL_WMASK;
            rdata_d[`SDDC_BIT_REF_STABLE] = ref_stable; // RULE9
        end else if (hit_irc) begin
            rdata_d[`SDDC_BIT_FLAG]      = flag_q;
            rdata_d[`SDDC_BIT_FLAG_IE]   = flag_ie_q;
            rdata_d[`SDDC_BIT_PERIPH_IE] = periph_ie_q;
            rdata_d[`SDDC_BIT_GLOBAL_IE] = global_ie_q;
        end else if (hit_sts) begin
            rdata_d[`SDDC_EV_WIDTH-1:0] = status_q;
        end else if (hit_msk) begin
            rdata_d[`SDDC_EV_WIDTH-1:0] = mask_q;
        end else if (hit_slp) begin
            rdata_d[0] = vector_pend_q;
        end
    end

    // Input synchronisers; only the later stages are looked at
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            below_sync_q <= 3'h0;
            osc_sync_q   <= 3'h0;
            below_q      <= 1'b0;
            osc_q        <= 1'b0;
        end else begin
            below_sync_q <= {below_sync_q[1:0], supply_below_trip};
            osc_sync_q   <= {osc_sync_q[1:0], fast_osc_running};
            below_q      <= below_d;
            osc_q        <= osc_d;
        end
    end

    // Control register and analog drive
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            control_q         <= `SDDC_CONTROL_RESET; // RULE2
            detector_power    <= 1'b0;
            trip_level_select <= `SDDC_LVL_RESET; // RULE2
        end else begin
            if (wr && hit_ctl) begin
                // Stable bit and reserved bits are never stored
                control_q <= pwdata[7:0] & `SDDC_CONTROL_WMASK;
            end
            detector_power    <= det_en;                          // RULE1
            trip_level_select <= control_q[`SDDC_LVL_HI:0];       // RULE2
        end
    end

    // Reference settle timer restarts whenever the detector is off
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            settle_q  <= {`SDDC_CNT_WIDTH{1'b0}};
            settled_q <= 1'b0;
        end else if (!det_en) begin
            settle_q  <= {`SDDC_CNT_WIDTH{1'b0}}; // RULE12
            settled_q <= 1'b0;
        end else if (settle_q == SETTLE_CNT) begin
            settled_q <= 1'b1; // RULE9
        end else begin
            settle_q <= settle_q + {{(`SDDC_CNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Flag, enables, events and mask
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_q      <= 1'b0;
            flag_ie_q   <= 1'b0;
            periph_ie_q <= 1'b0;
            global_ie_q <= 1'b0;
            status_q    <= {`SDDC_EV_WIDTH{1'b0}};
            mask_q      <= {`SDDC_EV_WIDTH{1'b0}};
        end else begin
            flag_q <= flag_d; // RULE3 RULE4 RULE6
            if (flag_wr) begin
                flag_ie_q   <= pwdata[`SDDC_BIT_FLAG_IE];
                periph_ie_q <= pwdata[`SDDC_BIT_PERIPH_IE];
                global_ie_q <= pwdata[`SDDC_BIT_GLOBAL_IE];
            end
            // Read clears only what was reported; a later event survives
            if (rd && hit_sts) begin
                status_q <= (status_q & ~prdata[`SDDC_EV_WIDTH-1:0]) | events;
            end else begin
                status_q <= status_q | events;
            end
            if (wr && hit_msk) begin
                mask_q <= pwdata[`SDDC_EV_WIDTH-1:0];
            end
        end
    end

    // Core hooks: wake level, vector request, pending vector after wake
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            core_wake     <= 1'b0;
            core_irq_req  <= 1'b0;
            vector_pend_q <= 1'b0;
            irq           <= 1'b0;
        end else begin
            core_wake    <= wake_cond & core_sleeping; // RULE7
            core_irq_req <= irq_cond;                  // RULE5 RULE8
            // Remember that a wake will be followed by a vector once an instruction retires
            if (wake_cond && core_sleeping && global_ie_q) begin
                vector_pend_q <= 1'b1; // RULE8
            end else if (!core_sleeping || !irq_cond) begin
                vector_pend_q <= 1'b0;
            end
            irq <= |((status_q | events) & mask_q);
        end
    end

    // APB answer: zero wait states, error on unmapped address
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

endmodule // sddc_supply_drop_detect
`default_nettype wire

/* File: sddc_chk.sv */
// Purpose: Port-level checks of the supply drop detector
// Assumes: One clock, active-low asynchronous reset
// Notes:   Bound onto every instance of the detector block
`timescale 1ns/1ns
`default_nettype none
module sddc_chk (
    // Clock, reset and APB
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Detector and core side
    input wire logic        supply_below_trip,
    input wire logic        fast_osc_running,
    input wire logic        detector_power,
    input wire logic        core_sleeping,
    input wire logic        core_wake,
    input wire logic        core_irq_req,
    input wire logic        irq,
    input wire logic [2:0]  trip_level_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Completed write to the control word; outputs may lag it by up to two cycles
    wire cw = psel && penable && pready && pwrite && paddr == 12'h000;
    ready_one_a: assert property (pready |=> !pready) else $error("pready held");
    ready_setup_a: assert property (psel && !penable |=> pready) else $error("no answer");
    ready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
    unmapped_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped data");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
    cfg_by_write_a: assert property ($changed({detector_power, trip_level_select}) |->
        $past(cw) || $past(cw, 2)) else $error("config moved");
    wake_sleep_a: assert property (core_wake |-> $past(core_sleeping)) else $error("wake awake");
    irq_wake_a: assert property (core_irq_req && $past(core_sleeping) |-> core_wake)
        else $error("no wake");
endmodule // sddc_chk
bind sddc_supply_drop_detect sddc_chk u_chk (.*);
`default_nettype wire

/* File: tb.sv */
// Purpose: Self-checking bench for the supply drop detector
// Assumes: APB answers after one access cycle
// Notes:   Settle wait is longer than the 500-cycle reference count
`timescale 1ns/1ns
`default_nettype none
module tb;
    // Bench-driven inputs
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        below = 0, osc = 1, slp = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    // Design outputs
    wire  [31:0] prdata;
    wire         pready, pslverr, pwr, wake, ireq, irq;
    wire  [2:0]  lvl;
    int          failures = 0, n_checks = 0;
    sddc_supply_drop_detect uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_below_trip(below), .fast_osc_running(osc), .detector_power(pwr), .trip_level_select(lvl),
        .core_sleeping(slp), .core_wake(wake), .core_irq_req(ireq), .irq(irq));
    // 25 MHz clock
    initial forever #20 clk = ~clk;
    // Compare one value
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            failures++;
            $display("CHECK FAILED apb pready exp 1 got %b", pready);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Read and compare
    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk("rdata", e, rd);
    endtask
    // Verdict, shared with the watchdog
    task finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Run takes under 2000 cycles
    initial begin
        #400000;
        failures++;
        finish_test;
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1;
        rchk(12'h000, 32'h04);
        chk("lvl", 4, lvl);
        // Every trip code with the detector on
        for (int i = 0; i < 8; i++) begin
            apb(1, 12'h000, 32'h10 | i);
            repeat (2) @(posedge clk);
            chk("lvl", i, lvl);
            chk("pwr", 1, pwr);
        end
        rchk(12'h000, 32'h17);
        // Disabled detector ignores a drop
        apb(1, 12'h000, 32'h07);
        repeat (2) @(posedge clk);
        chk("pwr", 0, pwr);
        below <= 1;
        repeat (10) @(posedge clk);
        below <= 0;
        rchk(12'h004, 32'h0);
        rchk(12'h000, 32'h07);
        // Enable, settle, then clear the flag with all enables set
        apb(1, 12'h000, 32'h17);
        repeat (520) @(posedge clk);
        rchk(12'h000, 32'h37);
        osc <= 0;
        repeat (8) @(posedge clk);
        rchk(12'h000, 32'h17);
        osc <= 1;
        apb(1, 12'h004, 32'h0E);
        apb(1, 12'h00C, 32'h3);
        // Supply drop, then recovery
        below <= 1;
        repeat (8) @(posedge clk);
        rchk(12'h004, 32'h0F);
        chk("ireq", 1, ireq);
        chk("irq", 1, irq);
        below <= 0;
        repeat (8) @(posedge clk);
        rchk(12'h004, 32'h0F);
        rchk(12'h008, 32'h1);
        rchk(12'h008, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq", 0, irq);
        // Software-set flag, with and without global enable
        apb(1, 12'h004, 32'h06);
        apb(1, 12'h004, 32'h07);
        repeat (2) @(posedge clk);
        chk("ireq", 0, ireq);
        apb(1, 12'h004, 32'h0F);
        repeat (2) @(posedge clk);
        chk("ireq", 1, ireq);
        // Wake from sleep
        apb(1, 12'h004, 32'h06);
        slp <= 1;
        apb(1, 12'h004, 32'h07);
        repeat (2) @(posedge clk);
        chk("wake", 1, wake);
        chk("ireq", 0, ireq);
        apb(1, 12'h004, 32'h0F);
        repeat (2) @(posedge clk);
        chk("ireq", 1, ireq);
        rchk(12'h010, 32'h1);
        rchk(12'h008, 32'h3);
        rchk(12'h00C, 32'h3);
        slp <= 0;
        repeat (2) @(posedge clk);
        chk("wake", 0, wake);
        rchk(12'h010, 32'h0);
        // Unmapped address
        rchk(12'h020, 32'h0);
        chk("err", 1, err);
        // Masked event sets status but not the interrupt line
        apb(1, 12'h00C, 32'h0);
        rchk(12'h008, 32'h2);
        apb(1, 12'h004, 32'h06);
        apb(1, 12'h004, 32'h07);
        repeat (2) @(posedge clk);
        chk("irq", 0, irq);
        rchk(12'h008, 32'h1);
        chk("err", 0, err);
        finish_test;
    end
endmodule // tb
`default_nettype wire
